// >>> core/cwt_ctrl.sv
// Overview of operation
// - Accept bus pulses between 0.5 and 500 us
// - Discarded pulse clears counter, no wake
// - Count accepted pulses, wake at three
// - Gap over 500 us clears counter
// - Wake flag holds until CAN normal mode
// - Control bit disables bus wake detection
// - TX low drives bus dominant
// - RX low while bus dominant
// - Normal mode entered within 10 us
// - Sample serial input on clock falling edge
// - Update serial output after rising edge
// - Stop-mode wake gives 10 us low interrupt
`timescale 1ns/10ps
`default_nettype none
`include "cwt_defines.svh"
module cwt_ctrl #(
  parameter int GAP_CYC = `CWT_GAP_MAX_CYC,
  parameter int PMAX_CYC = `CWT_PULSE_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Protocol handler pins
  input wire logic tx_data_in,
  output logic rx_data_out,
  // Bus side
  input wire logic bus_dominant_in,
  input wire logic wake_rx_in,
  output logic bus_drive_dom_out,
  // Mode
  input wire logic stop_mode_in,
  output logic can_normal_out,
  output logic wake_flag_out,
  output logic int_n_out,
  // SPI
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  // Received command stream
  output logic cmd_valid_out,
  output logic [`CWT_SPI_BITS-1:0] cmd_data_out,
  input wire logic cmd_ready_in
);
  localparam int W = `CWT_SPI_BITS;
  localparam int CW = 16;
  localparam logic [CW-1:0] PMIN = CW'(`CWT_PULSE_MIN_CYC);
  localparam logic [CW-1:0] PMAX = CW'(PMAX_CYC);
  localparam logic [CW-1:0] GAPM = CW'(GAP_CYC);
  // Sync latency is taken off so the whole path stays within the limit
  localparam logic [CW-1:0] CANN = CW'(`CWT_CANN_CYC - `CWT_SYNC_LAT);
  localparam logic [CW-1:0] INTC = CW'(`CWT_INT_CYC);
  localparam logic [1:0] NPUL = 2'(`CWT_WAKE_PULSES);

  // Two-stage synchronisers for all pins except reset_in, stop_mode_in and cmd_ready_in, which are used directly
  logic [5:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
  always_comb begin
    nxt_s1 = {tx_data_in, bus_dominant_in, wake_rx_in, spi_sclk_in, spi_cs_n_in, spi_mosi_in};
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge ref_clk_in) begin
    s1_ff <= reset_in ? `CWT_PIN_IDLE : nxt_s1;
    s2_ff <= reset_in ? `CWT_PIN_IDLE : nxt_s2;
  end
  logic tx_s, dom_s, wu_s, sck_s, cs_s, mosi_s;
  assign {tx_s, dom_s, wu_s, sck_s, cs_s, mosi_s} = s2_ff;

  // Transceiver data path
  logic drv_ff, rx_ff, nxt_drv, nxt_rx;
  always_comb begin
    nxt_drv = ~tx_s;
    nxt_rx = ~dom_s;
  end
  always_ff @(posedge ref_clk_in) begin
    drv_ff <= reset_in ? 1'b0 : nxt_drv;
    rx_ff <= reset_in ? 1'b1 : nxt_rx;
  end

  // SPI shift engine; edges seen in the same cycle the synced clock changes
  logic sck_d_ff, nxt_sck_d;
  logic [W-1:0] sh_ff, nxt_sh, tx_sh_ff, nxt_tx_sh;
  logic [3:0] bc_ff, nxt_bc;
  logic miso_ff, nxt_miso, word_ok, last_fall;
  logic [W-1:0] ctl_ff, nxt_ctl;
  logic fall, rise;
  assign fall = sck_d_ff & ~sck_s;
  assign rise = ~sck_d_ff & sck_s;
  assign last_fall = fall & ~cs_s & (bc_ff == 4'(W - 1));
  always_comb begin
    nxt_sck_d = sck_s;
    nxt_sh = sh_ff;
    nxt_bc = bc_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_miso = miso_ff;
    word_ok = 1'b0;
    if (cs_s) begin
      nxt_bc = 4'h0;
      nxt_tx_sh = {ctl_ff[W-1:2], wake_flag_out, can_normal_out};
      nxt_miso = 1'b0;
    end else begin
      if (fall) begin
        nxt_sh = {sh_ff[W-2:0], mosi_s};
        nxt_bc = last_fall ? 4'h0 : bc_ff + 4'h1;
        word_ok = last_fall;
      end
      if (rise) begin
        nxt_miso = tx_sh_ff[W-1];
        nxt_tx_sh = {tx_sh_ff[W-2:0], 1'b0};
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    sck_d_ff <= reset_in ? 1'b0 : nxt_sck_d;
    sh_ff <= reset_in ? 8'h00 : nxt_sh;
    bc_ff <= reset_in ? 4'h0 : nxt_bc;
    tx_sh_ff <= reset_in ? 8'h00 : nxt_tx_sh;
    miso_ff <= reset_in ? 1'b0 : nxt_miso;
  end
  logic [W-1:0] word;
  assign word = {sh_ff[W-2:0], mosi_s};

  // Two-entry buffer; a stalled reader keeps two words, overflow drops newest
  logic [W-1:0] buf_ff [2];
  logic [W-1:0] nxt_buf [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic pop, push;
  assign pop = cmd_valid_out & cmd_ready_in;
  assign push = word_ok & ((cnt_ff != 2'd2) | pop);
  always_comb begin
    nxt_buf = buf_ff;
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_cnt = nxt_cnt - 2'd1;
    end
    if (push) begin
      nxt_buf[nxt_cnt[0]] = word;
      nxt_cnt = nxt_cnt + 2'd1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    buf_ff[0] <= reset_in ? 8'h00 : nxt_buf[0];
    buf_ff[1] <= reset_in ? 8'h00 : nxt_buf[1];
    cnt_ff <= reset_in ? 2'd0 : nxt_cnt;
  end
  logic ovalid_ff;
  logic [W-1:0] odata_ff;
  always_ff @(posedge ref_clk_in) begin
    ovalid_ff <= reset_in ? 1'b0 : (nxt_cnt != 2'd0);
    odata_ff <= reset_in ? 8'h00 : nxt_buf[0];
  end

  // Control register and delayed normal mode entry
  logic [CW-1:0] md_ff, nxt_md;
  logic norm_ff, nxt_norm, wdis;
  assign wdis = ctl_ff[`CWT_CMD_WDIS_BIT];
  always_comb begin
    nxt_ctl = word_ok ? word : ctl_ff;
    nxt_md = md_ff;
    nxt_norm = norm_ff;
    if (!ctl_ff[`CWT_CMD_NORMAL_BIT]) begin
      nxt_norm = 1'b0;
      nxt_md = 16'h0000;
    end else if (!norm_ff) begin
      nxt_md = md_ff + 16'h0001;
      if (md_ff + 16'h0001 >= CANN) nxt_norm = 1'b1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    ctl_ff <= reset_in ? `CWT_CMD_RESET : nxt_ctl;
    md_ff <= reset_in ? 16'h0000 : nxt_md;
    norm_ff <= reset_in ? 1'b0 : nxt_norm;
  end

  // Wake pulse filter, counter and gap timer
  cwt_pkg::cwt_pulse_t st_ff, nxt_st;
  logic [CW-1:0] pw_ff, nxt_pw, gap_ff, nxt_gap;
  logic [1:0] pc_ff, nxt_pc;
  logic wf_ff, nxt_wf, wake_ev;
  always_comb begin
    nxt_st = st_ff;
    nxt_pw = pw_ff;
    nxt_pc = pc_ff;
    nxt_gap = gap_ff;
    wake_ev = 1'b0;
    if (pc_ff != 2'd0) begin
      nxt_gap = gap_ff + 16'h0001;
      if (gap_ff >= GAPM) begin
        nxt_pc = 2'd0;
        nxt_gap = 16'h0000;
      end
    end else begin
      nxt_gap = 16'h0000;
    end
    case (st_ff)
      // First high cycle already counts toward the width
      cwt_pkg::CWT_IDLE: begin
        nxt_pw = 16'h0001;
        nxt_st = wu_s ? cwt_pkg::CWT_LOW : cwt_pkg::CWT_HIGH;
      end
      cwt_pkg::CWT_HIGH: begin
        nxt_pw = 16'h0001;
        if (wu_s) nxt_st = cwt_pkg::CWT_LOW;
      end
      cwt_pkg::CWT_LOW: begin
        if (pw_ff != 16'hffff) nxt_pw = pw_ff + 16'h0001;
        if (!wu_s) begin
          nxt_st = cwt_pkg::CWT_HIGH;
          if (pw_ff > PMIN && pw_ff < PMAX) begin
            nxt_gap = 16'h0000;
            if (pc_ff + 2'd1 >= NPUL) begin
              wake_ev = 1'b1;
              nxt_pc = 2'd0;
            end else begin
              nxt_pc = pc_ff + 2'd1;
            end
          end else begin
            nxt_pc = 2'd0;
          end
        end
      end
      default: nxt_st = cwt_pkg::CWT_IDLE;
    endcase
    if (wdis) begin
      nxt_pc = 2'd0;
      wake_ev = 1'b0;
    end
    // Set wins over the clear
    nxt_wf = wake_ev | (wf_ff & ~norm_ff);
  end
  always_ff @(posedge ref_clk_in) begin
    st_ff <= reset_in ? cwt_pkg::CWT_IDLE : nxt_st;
    pw_ff <= reset_in ? 16'h0000 : nxt_pw;
    pc_ff <= reset_in ? 2'd0 : nxt_pc;
    gap_ff <= reset_in ? 16'h0000 : nxt_gap;
    wf_ff <= reset_in ? 1'b0 : nxt_wf;
  end

  // Stop-mode wake interrupt pulse
  logic [CW-1:0] ic_ff, nxt_ic;
  logic intn_ff, nxt_intn;
  always_comb begin
    nxt_ic = ic_ff;
    if (wake_ev && stop_mode_in) nxt_ic = INTC;
    else if (ic_ff != 16'h0000) nxt_ic = ic_ff - 16'h0001;
    nxt_intn = (nxt_ic == 16'h0000);
  end
  always_ff @(posedge ref_clk_in) begin
    ic_ff <= reset_in ? 16'h0000 : nxt_ic;
    intn_ff <= reset_in ? 1'b1 : nxt_intn;
  end

  assign rx_data_out = rx_ff;
  assign bus_drive_dom_out = drv_ff;
  assign can_normal_out = norm_ff;
  assign wake_flag_out = wf_ff;
  assign int_n_out = intn_ff;
  assign spi_miso_out = miso_ff;
  assign cmd_valid_out = ovalid_ff;
  assign cmd_data_out = odata_ff;
endmodule : cwt_ctrl
`default_nettype wire

// >>> core/cwt_defines.svh
`ifndef CWT_DEFINES_SVH
`define CWT_DEFINES_SVH
// Clock rate in kHz
`define CWT_CLK_KHZ 10000
// Filter and timeout limits
`define CWT_PULSE_MIN_NS 500
`define CWT_PULSE_MAX_US 500
`define CWT_GAP_MAX_US 500
`define CWT_CANN_MAX_US 10
`define CWT_INT_PULSE_US 10
// Least time rounds up; longest rounds down
`define CWT_PULSE_MIN_CYC ((`CWT_PULSE_MIN_NS * `CWT_CLK_KHZ + 999999) / 1000000)
`define CWT_PULSE_MAX_CYC ((`CWT_PULSE_MAX_US * `CWT_CLK_KHZ) / 1000)
`define CWT_GAP_MAX_CYC ((`CWT_GAP_MAX_US * `CWT_CLK_KHZ) / 1000)
`define CWT_CANN_CYC ((`CWT_CANN_MAX_US * `CWT_CLK_KHZ) / 1000)
`define CWT_INT_CYC ((`CWT_INT_PULSE_US * `CWT_CLK_KHZ) / 1000)
`define CWT_WAKE_PULSES 3
// Pin idle levels {tx, dom, wake, sclk, cs_n, mosi}; avoids false edges after reset
`define CWT_PIN_IDLE 6'h22
// Cycles lost to pin sync and command register before the mode timer starts
`define CWT_SYNC_LAT 3
// SPI command layout: 8 bits, bit 0 normal mode, bit 1 wake disable
`define CWT_SPI_BITS 8
`define CWT_CMD_NORMAL_BIT 0
`define CWT_CMD_WDIS_BIT 1
`define CWT_CMD_RESET 8'h00
`endif

// >>> core/cwt_pkg.sv
package cwt_pkg;
  typedef enum logic [2:0] {
    CWT_IDLE = 3'b001,
    CWT_HIGH = 3'b010,
    CWT_LOW = 3'b100
  } cwt_pulse_t;
endpackage : cwt_pkg

// >>> test/cwt_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "cwt_defines.svh"
module cwt_ctrl_sva #(parameter int GAP_CYC = 5000, parameter int PMAX_CYC = 5000) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Pins
  input wire logic tx_data_in,
  input wire logic rx_data_out,
  input wire logic bus_dominant_in,
  input wire logic bus_drive_dom_out,
  // Mode and wake
  input wire logic can_normal_out,
  input wire logic wake_flag_out,
  input wire logic int_n_out,
  input wire logic stop_mode_in,
  // Command stream
  input wire logic cmd_valid_out,
  input wire logic [`CWT_SPI_BITS-1:0] cmd_data_out,
  input wire logic cmd_ready_in
);
  // Pins lag three cycles, so four steady samples suffice
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_tx_dominant: assert property (!tx_data_in [*4] |-> bus_drive_dom_out)
    else $error("tx map");
  a_rx_dominant: assert property (bus_dominant_in [*4] |-> !rx_data_out)
    else $error("rx map dominant");
  a_rx_recessive: assert property (!bus_dominant_in [*4] |-> rx_data_out)
    else $error("rx map recessive");
  a_normal_on: assert property ($rose(cmd_valid_out) && cmd_data_out[0] |-> ##[90:100] can_normal_out)
    else $error("normal late");
  a_normal_off: assert property ($rose(cmd_valid_out) && !cmd_data_out[0] |=> !can_normal_out)
    else $error("normal stuck");
  a_wake_clear: assert property ($rose(can_normal_out) |=> !wake_flag_out)
    else $error("wake not cleared");
  a_wake_hold: assert property (wake_flag_out && !can_normal_out |=> wake_flag_out)
    else $error("wake lost");
  a_int_width: assert property ($fell(int_n_out) |-> ##99 !int_n_out ##1 int_n_out)
    else $error("int width");
  a_int_cause: assert property ($fell(int_n_out) |-> wake_flag_out && $past(stop_mode_in))
    else $error("int without stop-mode wake");
  a_cmd_hold: assert property (cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_data_out))
    else $error("cmd dropped");
  // Main scenarios reached
  c_normal: cover property ($rose(can_normal_out));
  c_wake: cover property ($rose(wake_flag_out));
  c_int: cover property ($fell(int_n_out));
endmodule : cwt_ctrl_sva
bind cwt_ctrl cwt_ctrl_sva #(.GAP_CYC(GAP_CYC), .PMAX_CYC(PMAX_CYC)) u_sva (.ref_clk_in, .reset_in,
  .tx_data_in, .rx_data_out, .bus_dominant_in, .bus_drive_dom_out, .can_normal_out, .wake_flag_out,
  .int_n_out, .stop_mode_in, .cmd_valid_out, .cmd_data_out, .cmd_ready_in);
`default_nettype wire

// >>> test/cwt_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module cwt_mcu_model (
  // Clock
  input wire logic clk_in,
  // SPI pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // Idle: clock low, deselected
  initial begin
    sclk_out = 1'h0;
    cs_n_out = 1'h1;
    mosi_out = 1'h0;
  end
  // Frame of 8 bits MSB first; mosi moves on the rise, far from the sampling fall
  task automatic xfer(input logic [7:0] d, input int half, output logic [7:0] q);
    @(posedge clk_in) #1;
    cs_n_out = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      repeat (half) @(posedge clk_in) #1;
      sclk_out = 1'h1;
      mosi_out = d[i];
      repeat (half) @(posedge clk_in) #1;
      sclk_out = 1'h0;
      q[i] = miso_in;
    end
    repeat (half) @(posedge clk_in) #1;
    cs_n_out = 1'h1;
    mosi_out = ~mosi_out; // Released line shows no stale bit
  endtask : xfer
endmodule : cwt_mcu_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst, tx, rx, bus_dom, wake_rx, drv, stop, norm, wake, int_n;
  logic sclk, cs_n, mosi, miso, vld, rdy;
  logic [7:0] cmd, q;
  int miscompares, num_checks;
  // Short counts keep the run brief
  cwt_ctrl #(.GAP_CYC(50), .PMAX_CYC(50)) dut (.ref_clk_in(clk), .reset_in(rst),
    .tx_data_in(tx), .rx_data_out(rx), .bus_dominant_in(bus_dom), .wake_rx_in(wake_rx),
    .bus_drive_dom_out(drv), .stop_mode_in(stop), .can_normal_out(norm),
    .wake_flag_out(wake), .int_n_out(int_n), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .cmd_valid_out(vld), .cmd_data_out(cmd),
    .cmd_ready_in(rdy));
  cwt_mcu_model mcu (.clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask : cyc
  task automatic chkv(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chkv
  task automatic chkb(input string n, input logic e, input logic s);
    chkv(n, {7'h0, e}, {7'h0, s});
  endtask : chkb
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // Bounded wait; running out ends the run
  task automatic await(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) cyc(1);
    if (s !== v) begin
      chkb("await", v, s);
      conclude;
    end
  endtask : await
  task automatic pulse(input int w, input int g);
    wake_rx = 1'h1;
    cyc(w);
    wake_rx = 1'h0;
    cyc(g);
  endtask : pulse
  task automatic t_path;
    tx = 1'h0;
    bus_dom = 1'h1;
    cyc(4);
    chkb("drive", 1'h1, drv);
    chkb("rx", 1'h0, rx);
    tx = 1'h1;
    bus_dom = 1'h0;
    cyc(4);
    chkb("drive", 1'h0, drv);
    chkb("rx", 1'h1, rx);
    $display("path done");
  endtask : t_path
  // Receiver stalls: third word is refused, two drain in order
  task automatic t_buf;
    rdy = 1'h0;
    for (int i = 1; i < 4; i++) mcu.xfer({i[3:0], 4'h0}, 4, q);
    cyc(8);
    for (int i = 1; i < 3; i++) begin
      chkb("valid", 1'h1, vld);
      chkv("cmd", {i[3:0], 4'h0}, cmd);
      rdy = 1'h1;
      cyc(1);
      rdy = 1'h0;
      cyc(2);
    end
    chkb("valid", 1'h0, vld);
    rdy = 1'h1;
    $display("buffer done");
  endtask : t_buf
  task automatic t_wake;
    int n;
    stop = 1'h1;
    pulse(10, 40);
    pulse(10, 40);
    chkb("wake", 1'h0, wake);
    pulse(10, 0);
    await(int_n, 1'h0, 30);
    for (n = 0; n < 200 && int_n === 1'h0; n++) cyc(1);
    chkv("int_len", 8'h64, n[7:0]);
    chkb("wake", 1'h1, wake);
    stop = 1'h0;
    cyc(200);
    chkb("wake", 1'h1, wake);
    mcu.xfer(8'h01, 8, q);
    await(norm, 1'h1, 100);
    cyc(2);
    chkb("wake", 1'h0, wake);
    mcu.xfer(8'h00, 4, q);
    cyc(8);
    chkb("normal", 1'h0, norm);
    $display("wake done");
  endtask : t_wake
  // Short, long and late pulse each restart the count
  task automatic t_reject;
    int wt[2] = '{5, 50};
    for (int k = 0; k < 3; k++) begin
      pulse(10, 10);
      pulse(10, 10);
      if (k < 2) pulse(wt[k], 10);
      else cyc(55);
      pulse(10, 10);
      pulse(10, 60);
      chkb("wake", 1'h0, wake);
    end
    $display("reject done");
  endtask : t_reject
  task automatic t_wdis;
    mcu.xfer(8'hfe, 4, q);
    chkv("status", 8'h00, q);
    mcu.xfer(8'hfe, 8, q);
    chkv("status", 8'hfc, q);
    for (int i = 0; i < 3; i++) pulse(10, 10);
    chkb("wake", 1'h0, wake);
    mcu.xfer(8'h00, 4, q);
    for (int i = 0; i < 3; i++) pulse(10, 10);
    chkb("wake", 1'h1, wake);
    chkb("int", 1'h1, int_n);
    $display("disable done");
  endtask : t_wdis
  initial begin
    {rst, tx, bus_dom, wake_rx, stop, rdy} = 6'h31;
    cyc(16);
    rst = 1'h0;
    cyc(4);
    t_path;
    t_buf;
    t_wake;
    t_reject;
    t_wdis;
    conclude;
  end
endmodule : tb_top
`default_nettype wire
